// ==== logic/gpa_pkg.sv ====
// gpa_pkg: constants, register map and carrier types of the port block
// assumes byte addressing on the register bus, one 32-bit word per register
package gpa_pkg;

	// port geometry
	localparam int GPA_PINS = 6;
	localparam int GPA_REG_W = 8;
	localparam int GPA_ADDR_W = 8;
	localparam int GPA_DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] GPA_ADDR_DIR = 8'h00;
	localparam logic [7:0] GPA_ADDR_LVL = 8'h04;
	localparam logic [7:0] GPA_ADDR_LAT = 8'h08;
	localparam logic [7:0] GPA_ADDR_ANA = 8'h0c;
	localparam logic [7:0] GPA_ADDR_APF = 8'h10;

	// implemented bits and fixed read values
	localparam logic [5:0] GPA_DIR_MASK = 6'h37;
	localparam logic [5:0] GPA_DIR_FIXED = 6'h08;
	localparam logic [5:0] GPA_LAT_MASK = 6'h37;
	localparam logic [5:0] GPA_ANA_MASK = 6'h17;
	localparam logic [7:0] GPA_APF_MASK = 8'h3b;

	// reset values
	localparam logic [5:0] GPA_DIR_RST = 6'h3f;
	localparam logic [5:0] GPA_LAT_RST = 6'h00;
	localparam logic [5:0] GPA_ANA_RST = 6'h17;
	localparam logic [7:0] GPA_APF_RST = 8'h00;

	// alternate-pin select bit positions
	localparam int GPA_APF_SDO = 5;
	localparam int GPA_APF_SS = 4;
	localparam int GPA_APF_TG = 3;
	localparam int GPA_APF_LC = 1;
	localparam int GPA_APF_OSC = 0;

	// pin indices used by steering
	localparam int GPA_PIN1 = 1;
	localparam int GPA_PIN2 = 2;
	localparam int GPA_PIN3 = 3;
	localparam int GPA_PIN4 = 4;
	localparam int GPA_PIN5 = 5;

	// one steerable peripheral output
	typedef struct packed {
		logic en;
		logic dat;
	} gpa_fn_out_t;

	// peripheral outputs that can be steered
	typedef struct packed {
		gpa_fn_out_t serial_out;
		gpa_fn_out_t logic_cell_output;
		gpa_fn_out_t numeric_osc_output;
	} gpa_periph_out_t;

	// peripheral inputs taken from the selected pin
	typedef struct packed {
		logic slave_select;
		logic timer_gate_input;
	} gpa_periph_in_t;

	// pad drive of one port
	typedef struct packed {
		logic [5:0] dat;
		logic [5:0] oe;
	} gpa_pad_t;

	typedef enum logic {
		GPA_ST_IDLE,
		GPA_ST_ACK
	} gpa_bus_st_t;

endpackage

// ==== logic/gpa_steer.sv ====
// gpa_steer: alternate-pin steering of peripheral functions, combinational
// assumes pad inputs already gated for analog select by the caller
`timescale 1ns/10ps
module gpa_steer
	import gpa_pkg::*;
(
	// alternate-pin control
	input  wire logic [7:0]              alt_pin_function_control,
	// normal port control
	input  wire gpa_pkg::gpa_pad_t       pa_gp,
	input  wire gpa_pkg::gpa_pad_t       pc_gp,
	// peripherals
	input  wire gpa_pkg::gpa_periph_out_t periph,
	output gpa_pkg::gpa_periph_in_t      fn_in,
	// pad levels, digital
	input  wire logic [5:0]              pa_in_dig,
	input  wire logic [5:0]              pc_in_dig,
	// steered drive
	output gpa_pkg::gpa_pad_t            pa_drv,
	output gpa_pkg::gpa_pad_t            pc_drv
);

	logic serial_out_pin_select;
	logic slave_select_pin_select;
	logic timer_gate_pin_select;
	logic logic_cell_pin_select;
	logic osc_output_pin_select;

	assign serial_out_pin_select = alt_pin_function_control[GPA_APF_SDO];
	assign slave_select_pin_select = alt_pin_function_control[GPA_APF_SS];
	assign timer_gate_pin_select = alt_pin_function_control[GPA_APF_TG];
	assign logic_cell_pin_select = alt_pin_function_control[GPA_APF_LC];
	assign osc_output_pin_select = alt_pin_function_control[GPA_APF_OSC];

	// output takeover; oe stays from direction bits
	always_comb begin
		pa_drv = pa_gp;
		pc_drv = pc_gp;
		if (periph.logic_cell_output.en) begin
			if (logic_cell_pin_select)
				pc_drv.dat[GPA_PIN5] = periph.logic_cell_output.dat;
			else
				pa_drv.dat[GPA_PIN2] = periph.logic_cell_output.dat;
		end
		if (periph.serial_out.en) begin
			if (serial_out_pin_select)
				pa_drv.dat[GPA_PIN4] = periph.serial_out.dat;
			else
				pc_drv.dat[GPA_PIN2] = periph.serial_out.dat;
		end
		// osc output outranks serial out on pin 4
		if (periph.numeric_osc_output.en) begin
			if (osc_output_pin_select)
				pa_drv.dat[GPA_PIN4] = periph.numeric_osc_output.dat;
			else
				pc_drv.dat[GPA_PIN1] = periph.numeric_osc_output.dat;
		end
	end

	// input routing
	always_comb begin
		fn_in.slave_select = slave_select_pin_select ?
			pa_in_dig[GPA_PIN3] : pc_in_dig[GPA_PIN3];
		fn_in.timer_gate_input = timer_gate_pin_select ?
			pa_in_dig[GPA_PIN3] : pa_in_dig[GPA_PIN4];
	end

endmodule // gpa_steer

// ==== logic/gpa_port.sv ====
// gpa_port: six-bit general-purpose port with alternate-pin steering
// assumes pad inputs synchronous to clk and an Avalon-MM master on the bus
//
// Behaviour
// - six-bit port, each pin with direction and level bits; pins 0-2, 4 and 5 bidirectional with latch bits.
// - direction bit 1 turns the pin driver off; pin is an input.
// - direction bit 0 drives the pin from its output latch bit.
// - pin 3 is input only; its direction bit always reads one.
// - reading the level register returns actual pin levels.
// - writing the level register updates the output latch.
// - reading the latch register returns latch contents, not pins.
// - port writes load written bits 0-2, 4 and 5 into the output latch; bit 3 is not latched.
// - analog select set disables the pin's digital input buffer.
// - digital reads of an analog-selected pin return zero.
// - analog select never gates digital output drive.
// - direction bits still control drivers on analog pins.
// - analog select bits reset to analog mode.
// - enabled peripheral output takes over pin; level stays readable.
// - alternate-pin bits leave direction bits alone; overrides follow selection.
// - unselected pin stays under normal port control.
// - serial out bit 5: 1 on port A pin 4, 0 port C pin 2.
// - slave select bit 4: 1 port A pin 3, 0 port C pin 3.
// - timer gate bit 3: 1 port A pin 3, 0 port A pin 4.
// - logic cell bit 1: 1 port C pin 5, 0 port A pin 2.
// - osc output bit 0: 1 port A pin 4, 0 port C pin 1.
// - alternate-pin bits 7, 6 and 2 read zero.
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/10ps
module gpa_port
	import gpa_pkg::*;
(
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     srst,
	// avalon-mm slave
	input  wire logic [GPA_ADDR_W-1:0]    avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [GPA_DATA_W-1:0]    avs_writedata,
	input  wire logic [3:0]               avs_byteenable,
	output logic      [GPA_DATA_W-1:0]    avs_readdata,
	output logic                          avs_waitrequest,
	// port a pads
	input  wire logic [GPA_PINS-1:0]      pa_in,
	output gpa_pkg::gpa_pad_t             pa_pad,
	output logic      [GPA_PINS-1:0]      pa_ibuf_en,
	// port c pads and its normal control
	input  wire logic [GPA_PINS-1:0]      pc_in,
	input  wire gpa_pkg::gpa_pad_t        pc_gp,
	output gpa_pkg::gpa_pad_t             pc_pad,
	// peripherals
	input  wire gpa_pkg::gpa_periph_out_t periph,
	output gpa_pkg::gpa_periph_in_t       periph_in
);

	import gpa_pkg::*;

	// register state
	logic [5:0] pin_direction_bits_reg;
	logic [5:0] pin_direction_bits_next;
	logic [5:0] output_latch_register_reg;
	logic [5:0] output_latch_register_next;
	logic [5:0] analog_select_bits_reg;
	logic [5:0] analog_select_bits_next;
	logic [7:0] alt_pin_function_control_reg;
	logic [7:0] alt_pin_function_control_next;

	// bus state
	gpa_bus_st_t              bus_st_reg;
	gpa_bus_st_t              bus_st_next;
	logic [GPA_DATA_W-1:0]    readdata_reg;
	logic [GPA_DATA_W-1:0]    readdata_next;
	logic                     waitrequest_reg;
	logic                     waitrequest_next;

	// pad state
	gpa_pad_t                 pa_pad_reg;
	gpa_pad_t                 pc_pad_reg;
	gpa_periph_in_t           periph_in_reg;
	logic [GPA_PINS-1:0]      ibuf_en_reg;

	// decode
	logic                     req;
	logic                     commit_wr;
	logic                     lane0;
	logic                     hit_dir;
	logic                     hit_lvl;
	logic                     hit_lat;
	logic                     hit_ana;
	logic                     hit_apf;

	// derived port values
	logic [5:0]               dir_eff;
	logic [5:0]               pin_level_register;
	logic [5:0]               wr_byte;
	logic [7:0]               rd_byte;
	gpa_pad_t                 pa_gp;
	gpa_pad_t                 pa_drv;
	gpa_pad_t                 pc_drv;
	gpa_periph_in_t           fn_in;

	assign req = avs_read | avs_write;
	assign lane0 = avs_byteenable[0];
	assign hit_dir = (avs_address == GPA_ADDR_DIR);
	assign hit_lvl = (avs_address == GPA_ADDR_LVL);
	assign hit_lat = (avs_address == GPA_ADDR_LAT);
	assign hit_ana = (avs_address == GPA_ADDR_ANA);
	assign hit_apf = (avs_address == GPA_ADDR_APF);
	assign wr_byte = avs_writedata[5:0];

	// write takes effect at the edge where waitrequest is seen low
	assign commit_wr = (bus_st_reg == GPA_ST_ACK) & avs_write & lane0;

	// pin 3 direction fixed at input
	assign dir_eff = (pin_direction_bits_reg & GPA_DIR_MASK)
		| GPA_DIR_FIXED;

	// digital read path, analog pins read zero
	assign pin_level_register = pa_in
		& ~(analog_select_bits_reg & GPA_ANA_MASK);

	// normal port control per pin
	genvar i;
	generate
		for (i = 0; i < GPA_PINS; i++) begin : g_pin
			// driver on only with direction 0; analog select not used here
			assign pa_gp.oe[i] = ~dir_eff[i];
			assign pa_gp.dat[i] = output_latch_register_reg[i];
		end
	endgenerate

	gpa_steer u_steer (
		.alt_pin_function_control (alt_pin_function_control_reg),
		.pa_gp                    (pa_gp),
		.pc_gp                    (pc_gp),
		.periph                   (periph),
		.fn_in                    (fn_in),
		.pa_in_dig                (pin_level_register),
		.pc_in_dig                (pc_in),
		.pa_drv                   (pa_drv),
		.pc_drv                   (pc_drv)
	);

	// direction register
	always_comb begin
		pin_direction_bits_next = pin_direction_bits_reg;
		if (commit_wr && hit_dir)
			pin_direction_bits_next = wr_byte & GPA_DIR_MASK;
	end

	always_ff @(posedge clk) begin
		if (srst)
			pin_direction_bits_reg <= GPA_DIR_RST;
		else
			pin_direction_bits_reg <= pin_direction_bits_next;
	end

	// output latch, written from either port register
	always_comb begin
		output_latch_register_next = output_latch_register_reg;
		if (commit_wr && (hit_lvl || hit_lat))
			output_latch_register_next = wr_byte & GPA_LAT_MASK;
	end

	always_ff @(posedge clk) begin
		if (srst)
			output_latch_register_reg <= GPA_LAT_RST;
		else
			output_latch_register_reg <= output_latch_register_next;
	end

	// analog select
	always_comb begin
		analog_select_bits_next = analog_select_bits_reg;
		if (commit_wr && hit_ana)
			analog_select_bits_next = wr_byte & GPA_ANA_MASK;
	end

	always_ff @(posedge clk) begin
		if (srst)
			analog_select_bits_reg <= GPA_ANA_RST;
		else
			analog_select_bits_reg <= analog_select_bits_next;
	end

	// alternate-pin control
	always_comb begin
		alt_pin_function_control_next = alt_pin_function_control_reg;
		if (commit_wr && hit_apf)
			alt_pin_function_control_next = avs_writedata[7:0]
				& GPA_APF_MASK;
	end

	always_ff @(posedge clk) begin
		if (srst)
			alt_pin_function_control_reg <= GPA_APF_RST;
		else
			alt_pin_function_control_reg <= alt_pin_function_control_next;
	end

	// read mux
	always_comb begin
		rd_byte = 8'h00;
		case (1'b1)
			hit_dir: rd_byte = {2'b00, dir_eff};
			hit_lvl: rd_byte = {2'b00, pin_level_register};
			hit_lat: rd_byte = {2'b00,
				output_latch_register_reg & GPA_LAT_MASK};
			hit_ana: rd_byte = {2'b00,
				analog_select_bits_reg & GPA_ANA_MASK};
			hit_apf: rd_byte = alt_pin_function_control_reg
				& GPA_APF_MASK;
			default: rd_byte = 8'h00;
		endcase
	end

	// bus handshake: one wait cycle, then one answer cycle
	always_comb begin
		bus_st_next = bus_st_reg;
		waitrequest_next = 1'b1;
		readdata_next = readdata_reg;
		case (bus_st_reg)
			GPA_ST_IDLE: begin
				if (req) begin
					bus_st_next = GPA_ST_ACK;
					waitrequest_next = 1'b0;
					readdata_next = {{(GPA_DATA_W - GPA_REG_W){1'b0}}, rd_byte};
				end
			end
			GPA_ST_ACK: begin
				bus_st_next = GPA_ST_IDLE;
				waitrequest_next = 1'b1;
			end
			default: begin
				bus_st_next = GPA_ST_IDLE;
				waitrequest_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst)
			bus_st_reg <= GPA_ST_IDLE;
		else
			bus_st_reg <= bus_st_next;
	end

	always_ff @(posedge clk) begin
		if (srst)
			waitrequest_reg <= 1'b1;
		else
			waitrequest_reg <= waitrequest_next;
	end

	always_ff @(posedge clk) begin
		if (srst)
			readdata_reg <= '0;
		else
			readdata_reg <= readdata_next;
	end

	// pad drive flops
	always_ff @(posedge clk) begin
		if (srst) begin
			pa_pad_reg <= '0;
			pc_pad_reg <= '0;
		end else begin
			pa_pad_reg <= pa_drv;
			pc_pad_reg <= pc_drv;
		end
	end

	// input buffer enables and routed peripheral inputs
	always_ff @(posedge clk) begin
		if (srst) begin
			ibuf_en_reg <= '0;
			periph_in_reg <= '0;
		end else begin
			ibuf_en_reg <= ~(analog_select_bits_reg & GPA_ANA_MASK);
			periph_in_reg <= fn_in;
		end
	end

	assign avs_readdata = readdata_reg;
	assign avs_waitrequest = waitrequest_reg;
	assign pa_pad = pa_pad_reg;
	assign pc_pad = pc_pad_reg;
	assign pa_ibuf_en = ibuf_en_reg;
	assign periph_in = periph_in_reg;

endmodule // gpa_port

// ==== tb/gpa_port_props.sv ====
// gpa_port_props: bus and pad assertions for gpa_port
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/10ps
module gpa_port_props
	import gpa_pkg::*;
(
	// clock and reset
	input wire logic                    clk,
	input wire logic                    srst,
	// register bus
	input wire logic                    avs_read,
	input wire logic                    avs_write,
	input wire logic [GPA_DATA_W-1:0]   avs_readdata,
	input wire logic                    avs_waitrequest,
	// pads and peripherals
	input wire gpa_pkg::gpa_pad_t       pa_pad,
	input wire logic [GPA_PINS-1:0]     pa_ibuf_en,
	input wire gpa_pkg::gpa_pad_t       pc_gp,
	input wire gpa_pkg::gpa_pad_t       pc_pad,
	input wire gpa_pkg::gpa_periph_out_t periph
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// request seen while idle, then one-cycle answer
	sequence req_s;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence ack_s;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	ans_next_a: assert property (req_s |=> ack_s)
		else $error("bus answer late or long");
	ans_cause_a: assert property ($fell(avs_waitrequest) |->
		$past(avs_read || avs_write)) else $error("answer without request");
	rd_upper_a: assert property (avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	pin3_off_a: assert property (!pa_pad.oe[3])
		else $error("input-only pin driven");
	ibuf_fixed_a: assert property (!$past(srst) |->
		pa_ibuf_en[3] && pa_ibuf_en[5]) else $error("fixed buffer off");
	pc_oe_a: assert property (!$past(srst) |->
		pc_pad.oe == $past(pc_gp.oe)) else $error("port c enable wrong");
	pc_free_a: assert property (!$past(srst) &&
		!$past(periph.serial_out.en || periph.logic_cell_output.en ||
		periph.numeric_osc_output.en) |-> pc_pad.dat == $past(pc_gp.dat))
		else $error("port c data disturbed");
	pc_sdo_a: assert property (!$past(srst) |->
		pc_pad.dat[2] == $past(pc_gp.dat[2]) ||
		($past(periph.serial_out.en) &&
		pc_pad.dat[2] == $past(periph.serial_out.dat)))
		else $error("port c pin2 data wrong");
endmodule // gpa_port_props

bind gpa_port gpa_port_props u_props (.clk(clk), .srst(srst),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.pa_pad(pa_pad), .pa_ibuf_en(pa_ibuf_en), .pc_gp(pc_gp),
	.pc_pad(pc_pad), .periph(periph));

// ==== tb/gpa_port_tb_top.sv ====
// gpa_port_tb_top: self-checking bench for gpa_port
// assumes gpa_pkg, the design and the checker compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %0t got %h exp %h", $time, g, e); end end
module gpa_port_tb_top;
	import gpa_pkg::*;
	logic            clk = 0, srst = 1, snap = 0, rd = 0, wr = 0, wq;
	logic [3:0]      be = 4'hf;
	logic [7:0]      adr = 0, fv;
	logic [31:0]     wd = 0, rdat, ev, r, seed = 33;
	logic [5:0]      pa_in = 0, pc_in = 0, ibuf, dv, lv, av;
	gpa_pad_t        pa_pad, pc_pad, pc_gp = 0;
	gpa_periph_out_t periph = 0;
	gpa_periph_in_t  p_in;
	logic [31:0]     q[$];
	int              n_errors = 0, cmp_count = 0, cyc = 0;
	wire [31:0]      snap_v = {ibuf, pa_pad.dat & pa_pad.oe, pa_pad.oe,
		pc_pad, p_in};

	gpa_port uut (.clk(clk), .srst(srst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wq), .pa_in(pa_in), .pa_pad(pa_pad),
		.pa_ibuf_en(ibuf), .pc_in(pc_in), .pc_gp(pc_gp),
		.pc_pad(pc_pad), .periph(periph), .periph_in(p_in));

	initial forever #2 clk = ~clk;

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected pads, buffers and steered inputs from the model registers
	function logic [31:0] pads();
		logic [5:0] oe, pd, cd, dig;
		oe = ~dv;
		pd = lv;
		cd = pc_gp.dat;
		dig = pa_in & ~av;
		if (!fv[1] && periph.logic_cell_output.en)
			pd[2] = periph.logic_cell_output.dat;
		if (fv[1] && periph.logic_cell_output.en)
			cd[5] = periph.logic_cell_output.dat;
		if (fv[0] && periph.numeric_osc_output.en)
			pd[4] = periph.numeric_osc_output.dat;
		else if (fv[5] && periph.serial_out.en)
			pd[4] = periph.serial_out.dat;
		if (!fv[0] && periph.numeric_osc_output.en)
			cd[1] = periph.numeric_osc_output.dat;
		if (!fv[5] && periph.serial_out.en)
			cd[2] = periph.serial_out.dat;
		return {~av, pd & oe, oe, cd, pc_gp.oe,
			fv[4] ? dig[3] : pc_in[3], fv[3] ? dig[3] : dig[4]};
	endfunction

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wq !== 1'b0);
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask

	task rreg(input logic [7:0] a, input logic [7:0] e);
		q.push_back({24'h0, e});
		bus(1'b0, a, 32'h0);
	endtask

	task chk_pads();
		q.push_back(pads());
		snap <= 1;
		@(posedge clk);
		snap <= 0;
	endtask

	task setregs(input logic [31:0] d, l, a, f, input logic s);
		bus(1'b1, 8'h00, d);
		dv = d[5:0] & 6'h37 | 6'h08;
		bus(1'b1, s ? 8'h04 : 8'h08, l);
		lv = l[5:0] & 6'h37;
		bus(1'b1, 8'h0c, a);
		av = a[5:0] & 6'h17;
		bus(1'b1, 8'h10, f);
		fv = f[7:0] & 8'h3b;
	endtask

	task summarize();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// scoreboard and timeout
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			summarize();
		end else begin
			if (rd && wq === 1'b0) begin
				ev = q.pop_front();
				`CHK(rdat, ev)
			end
			if (snap) begin
				ev = q.pop_front();
				`CHK(snap_v, ev)
			end
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		dv = 6'h3f;
		lv = 6'h00;
		av = 6'h17;
		fv = 8'h00;
		rreg(8'h00, 8'h3f);
		rreg(8'h0c, 8'h17);
		rreg(8'h10, 8'h00);
		rreg(8'h14, 8'h00);
		chk_pads();
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			pa_in <= r[5:0];
			pc_in <= r[11:6];
			pc_gp <= r[23:12];
			periph <= r[29:24];
			setregs(rnd(), rnd(), rnd(), rnd(), i[0]);
			rreg(8'h00, {2'b0, dv});
			rreg(8'h10, fv);
			rreg(8'h08, {2'b0, lv});
			rreg(8'h04, {2'b0, pa_in & ~av});
			chk_pads();
		end
		// second reset mid-run, registers back to reset values
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		dv = 6'h3f;
		lv = 6'h00;
		av = 6'h17;
		fv = 8'h00;
		rreg(8'h10, 8'h00);
		rreg(8'h0c, 8'h17);
		rreg(8'h00, 8'h3f);
		// write with lane 0 off is ignored
		be <= 4'he;
		bus(1'b1, 8'h08, 32'h3f);
		be <= 4'hf;
		rreg(8'h08, 8'h00);
		chk_pads();
		summarize();
	end
endmodule // gpa_port_tb_top
